/* File: inc/uart_fifo_ctrl_cfg.svh */
// offsets, field positions, reset values and timing counts of the fifo control block
`ifndef UART_FIFO_CTRL_CFG_SVH
`define UART_FIFO_CTRL_CFG_SVH
// byte offsets on the register bus
`define OFS_DATA 4'h0
`define OFS_IRQ_ENABLE 4'h4
`define OFS_CTRL_STATUS 4'h8
`define OFS_LEVELS 4'hC
// fifo_control field positions
`define FC_ENABLE 0
`define FC_RX_CLEAR 1
`define FC_TX_CLEAR 2
`define FC_DMA_MODE 3
`define FC_DEEP 5
`define FC_TRIG_LO 6
// interrupt enable field positions
`define IE_RX 0
`define IE_THR 1
`define IE_LINE 2
`define IE_MODEM 3
// reset values
`define FC_RESET 8'h00
`define IE_RESET 4'h0
// depths and trigger levels
`define DEPTH_SHALLOW 7'h10
`define DEPTH_DEEP 7'h40
`define TX_TRIG_SHALLOW 7'h08
`define TX_TRIG_DEEP 7'h20
// receive time-out in character times
`define RX_TIMEOUT_CHARS 3'h4
`endif

/* File: inc/uart_fifo_ctrl_pkg.sv */
// types shared by the fifo control block
package uart_fifo_ctrl_pkg;
  // interrupt sources, highest priority first
  typedef enum logic [2:0] {SRC_NONE, SRC_LINE, SRC_RXDATA, SRC_TIMEOUT, SRC_THR, SRC_MODEM} src_e;
  // byte handed to the transmit shift register
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } txbyte_s;
  // character arriving from the receive shift register
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rxchar_s;
endpackage

/* File: hdl/uart_fifo_ctrl.sv */
// fifo control, dma request pins and prioritized interrupt status of a uart
`timescale 1ns/1ps
`include "uart_fifo_ctrl_cfg.svh"

// What this block does
// - dma mode 1: tx request pin high when tx fifo full, low at trigger
// - dma mode 1: rx request low at trigger or time-out, high only when empty
// - tx clear bit 2 empties tx fifo and counters, shift register untouched
// - rx clear bit 1 empties rx fifo and counters, shift register untouched
// - both clear bits act once and revert to zero by themselves
// - enable bit 0 enables both fifos together; reset value zero
// - other control bits are taken only when enable is written one alongside
// - rx trigger codes give 1,4,8,14 or 1,16,32,56 bytes
// - status read returns code of the held interrupt, chosen by priority when none is held
// - no other interrupt reported until the current one is serviced
// - status read clears only the reported interrupt; lower ones show next
// - line status interrupt is priority 1, code 0110
// - rx data ready 0100 and rx time-out 1100 share priority 2
// - tx holding empty priority 3 code 0010; modem status priority 4 code 0000
// - status bits 7 and 6 read one while fifos enabled
// - status bit 5 shows 64-byte mode; bit 4 reads zero
// - status bit 0 is zero while an interrupt is pending; resets to one
// - control bit 5 selects 64-byte depth; reset selects 16 bytes
// - rx trigger fires when count reaches level; fifo fills until full
// - control bit 3 selects dma mode 1; reset selects mode 0
module uart_fifo_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // receive shift register side
  input wire uart_fifo_ctrl_pkg::rxchar_s rxChar,
  input wire logic lineError,
  input wire logic charTick,
  // transmit shift register side
  input wire logic txLoad,
  output uart_fifo_ctrl_pkg::txbyte_s txByte,
  // modem status change
  input wire logic modemChange,
  // dma request pins and interrupt
  output logic txDmaRequest_n,
  output logic rxDmaRequest_n,
  output logic irq
);
  import uart_fifo_ctrl_pkg::*;
  localparam logic [7:0] fcReset = `FC_RESET;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // receive trigger level from the two-bit code and depth mode
  function automatic logic [6:0] rxTrigLevel(input logic [1:0] sel, input logic deep);
    logic [6:0] lvl;
    lvl = 7'h01;
    unique case (sel)
      2'b00: lvl = 7'h01;
      2'b01: lvl = deep ? 7'h10 : 7'h04;
      2'b10: lvl = deep ? 7'h20 : 7'h08;
      2'b11: lvl = deep ? 7'h38 : 7'h0E;
    endcase
    return lvl;
  endfunction

  // usable depth; one holding byte while fifos are off
  function automatic logic [6:0] depthOf(input logic en, input logic deep);
    return !en ? 7'h01 : (deep ? `DEPTH_DEEP : `DEPTH_SHALLOW);
  endfunction

  // interrupt code bits 3..0 of a source
  function automatic logic [3:0] srcCode(input src_e s);
    logic [3:0] c;
    c = 4'h1;
    unique case (s)
      SRC_NONE: c = 4'h1;
      SRC_LINE: c = 4'h6;
      SRC_RXDATA: c = 4'h4;
      SRC_TIMEOUT: c = 4'hC;
      SRC_THR: c = 4'h2;
      SRC_MODEM: c = 4'h0;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic fifoEn_q;
  logic dmaMode_q;
  logic deep_q;
  logic [1:0] trigSel_q;
  logic [3:0] irqEn_q;
  logic [7:0] rxMem [0:63];
  logic [7:0] txMem [0:63];
  logic [5:0] rxRd_q;
  logic [5:0] rxWr_q;
  logic [6:0] rxCnt_q;
  logic [5:0] txRd_q;
  logic [5:0] txWr_q;
  logic [6:0] txCnt_q;
  logic linePend_q;
  logic modemPend_q;
  logic thrPend_q;
  logic timeout_q;
  logic [2:0] tmoCnt_q;
  src_e cur_q;
  src_e capSrc_q;
  logic wait_q;
  logic [31:0] rdata_q;
  txbyte_s txByte_q;
  logic txReqN_q;
  logic rxReqN_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // a request is accepted at the edge where waitrequest is seen low
  wire req = read | write;
  wire accept = req & ~wait_q;
  wire wrLane = byteenable[0];
  wire selData = address[3:2] == `OFS_DATA >> 2;
  wire selIe = address[3:2] == `OFS_IRQ_ENABLE >> 2;
  wire selCs = address[3:2] == `OFS_CTRL_STATUS >> 2;
  wire selLvl = address[3:2] == `OFS_LEVELS >> 2;
  wire wrData = accept & write & wrLane & selData;
  wire wrIe = accept & write & wrLane & selIe;
  wire wrFc = accept & write & wrLane & selCs;
  wire rdData = accept & read & selData;
  wire rdStatus = accept & read & selCs;

  // ----------------------------------------------------------------
  // fifo control decode
  // ----------------------------------------------------------------

  // other fields only land when enable is written one
  wire fcTake = wrFc & writedata[`FC_ENABLE];
  wire enToggle = wrFc & (writedata[`FC_ENABLE] != fifoEn_q);
  wire txClr = (fcTake & writedata[`FC_TX_CLEAR]) | enToggle;
  wire rxClr = (fcTake & writedata[`FC_RX_CLEAR]) | enToggle;
  wire [6:0] depth = depthOf(fifoEn_q, deep_q);
  wire [6:0] rxTrig = fifoEn_q ? rxTrigLevel(trigSel_q, deep_q) : 7'h01;
  wire [6:0] txTrig = deep_q ? `TX_TRIG_DEEP : `TX_TRIG_SHALLOW;

  // ----------------------------------------------------------------
  // fifo pointers and counts
  // ----------------------------------------------------------------

  // receive fifo keeps filling past the trigger until full
  wire rxFull = rxCnt_q >= depth;
  wire rxPush = rxChar.valid & ~rxFull & ~rxClr;
  wire rxPop = rdData & (rxCnt_q != 7'h00) & ~rxClr;
  wire overrun = rxChar.valid & rxFull;
  wire txFull = txCnt_q >= depth;
  wire txPush = wrData & ~txFull & ~txClr;
  wire txPop = txLoad & (txCnt_q != 7'h00) & ~txClr;
  wire rxAtTrig = fifoEn_q & (rxCnt_q >= rxTrig);
  wire rxHasData = rxCnt_q != 7'h00;

  // storage writes, no reset needed on the data itself
  always_ff @(posedge clk) begin
    if (rxPush) begin
      rxMem[rxWr_q] <= rxChar.data;
    end
    if (txPush) begin
      txMem[txWr_q] <= writedata[7:0];
    end
  end

  // clear empties pointers and counts only, never the shift registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxRd_q <= 6'h00;
      rxWr_q <= 6'h00;
      rxCnt_q <= 7'h00;
    end else if (rxClr) begin
      rxRd_q <= 6'h00;
      rxWr_q <= 6'h00;
      rxCnt_q <= 7'h00;
    end else begin
      rxWr_q <= rxPush ? rxWr_q + 6'h01 : rxWr_q;
      rxRd_q <= rxPop ? rxRd_q + 6'h01 : rxRd_q;
      rxCnt_q <= rxCnt_q + {6'h00, rxPush} - {6'h00, rxPop};
    end
  end

  // transmit side pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txRd_q <= 6'h00;
      txWr_q <= 6'h00;
      txCnt_q <= 7'h00;
    end else if (txClr) begin
      txRd_q <= 6'h00;
      txWr_q <= 6'h00;
      txCnt_q <= 7'h00;
    end else begin
      txWr_q <= txPush ? txWr_q + 6'h01 : txWr_q;
      txRd_q <= txPop ? txRd_q + 6'h01 : txRd_q;
      txCnt_q <= txCnt_q + {6'h00, txPush} - {6'h00, txPop};
    end
  end

  // byte to the transmit shift register, one cycle after txLoad
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txByte_q <= '0;
    end else begin
      txByte_q.valid <= txPop;
      txByte_q.data <= txPop ? txMem[txRd_q] : txByte_q.data;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------

  // fifo_control holds enable, depth, dma mode and trigger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifoEn_q <= fcReset[`FC_ENABLE];
      dmaMode_q <= fcReset[`FC_DMA_MODE];
      deep_q <= fcReset[`FC_DEEP];
      trigSel_q <= fcReset[`FC_TRIG_LO +: 2];
    end else if (wrFc) begin
      fifoEn_q <= writedata[`FC_ENABLE];
      if (fcTake) begin
        dmaMode_q <= writedata[`FC_DMA_MODE];
        deep_q <= writedata[`FC_DEEP];
        trigSel_q <= writedata[`FC_TRIG_LO +: 2];
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEn_q <= `IE_RESET;
    end else if (wrIe) begin
      irqEn_q <= writedata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // receive time-out
  // ----------------------------------------------------------------

  // idle character times counted while data sits below the trigger
  wire tmoArm = fifoEn_q & rxHasData & ~rxAtTrig;
  wire tmoHit = tmoArm & charTick & (tmoCnt_q == `RX_TIMEOUT_CHARS - 3'h1);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmoCnt_q <= 3'h0;
      timeout_q <= 1'b0;
    end else begin
      if (rxPush | rxPop | rxClr | ~tmoArm) begin
        tmoCnt_q <= 3'h0;
      end else if (charTick & ~timeout_q) begin
        tmoCnt_q <= tmoCnt_q + 3'h1;
      end
      // a hit wins over a clear in the same cycle
      if (tmoHit) begin
        timeout_q <= 1'b1;
      end else if (rxPop | rxClr | ~rxHasData) begin
        timeout_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------

  // status read clears only the source it reported
  wire clrLine = rdStatus & (capSrc_q == SRC_LINE);
  wire clrModem = rdStatus & (capSrc_q == SRC_MODEM);
  wire clrThr = (rdStatus & (capSrc_q == SRC_THR)) | txPush;
  wire txGoesEmpty = txPop & (txCnt_q == 7'h01);

  // sticky sources; a new event wins over its clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linePend_q <= 1'b0;
      modemPend_q <= 1'b0;
      thrPend_q <= 1'b0;
    end else begin
      linePend_q <= (lineError | overrun) | (linePend_q & ~clrLine);
      modemPend_q <= modemChange | (modemPend_q & ~clrModem);
      thrPend_q <= txGoesEmpty | txClr | (thrPend_q & ~clrThr);
    end
  end

  // enabled pending sources
  wire pLine = linePend_q & irqEn_q[`IE_LINE];
  wire pRxd = (fifoEn_q ? rxAtTrig : rxHasData) & irqEn_q[`IE_RX];
  wire pTmo = timeout_q & irqEn_q[`IE_RX];
  wire pThr = thrPend_q & irqEn_q[`IE_THR];
  wire pModem = modemPend_q & irqEn_q[`IE_MODEM];

  // fixed priority pick
  wire src_e best = pLine ? SRC_LINE : pRxd ? SRC_RXDATA : pTmo ? SRC_TIMEOUT
                  : pThr ? SRC_THR : pModem ? SRC_MODEM : SRC_NONE;

  // reported source holds until it is no longer pending
  wire curLive = (cur_q == SRC_LINE & pLine) | (cur_q == SRC_RXDATA & pRxd)
               | (cur_q == SRC_TIMEOUT & pTmo) | (cur_q == SRC_THR & pThr)
               | (cur_q == SRC_MODEM & pModem);
  wire src_e cur_d = curLive ? cur_q : best;

  // status byte: fifo flags, depth, code, pending low
  wire [7:0] statusByte = {fifoEn_q, fifoEn_q, deep_q & fifoEn_q, 1'b0,
                           srcCode(cur_q)};

  // ----------------------------------------------------------------
  // interrupt state and output
  // ----------------------------------------------------------------

  // current source register and interrupt pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= SRC_NONE;
      irq_q <= 1'b0;
    end else begin
      cur_q <= cur_d;
      irq_q <= cur_d != SRC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // dma request pins
  // ----------------------------------------------------------------

  // mode 1 keeps hysteresis; mode 0 follows occupancy
  wire mode1 = fifoEn_q & dmaMode_q;
  wire txReqN_d = !mode1 ? (txCnt_q != 7'h00)
                : txFull ? 1'b1
                : (txCnt_q <= txTrig) ? 1'b0 : txReqN_q;
  wire rxReqN_d = !mode1 ? ~rxHasData
                : ~rxHasData ? 1'b1
                : (rxAtTrig | timeout_q) ? 1'b0 : rxReqN_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txReqN_q <= 1'b0;
      rxReqN_q <= 1'b1;
    end else begin
      txReqN_q <= txReqN_d;
      rxReqN_q <= rxReqN_d;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------

  // read data per offset; unmapped reads return zero
  wire [7:0] rdByte = selData ? (rxHasData ? rxMem[rxRd_q] : 8'h00)
                    : selIe ? {4'h0, irqEn_q}
                    : selCs ? statusByte
                    : selLvl ? {1'b0, rxCnt_q}
                    : 8'h00;
  wire [31:0] rdWord = selLvl ? {9'h000, txCnt_q, 16'h0000} | {24'h00_0000, rdByte}
                     : {24'h00_0000, rdByte};

  // one wait cycle, then the request is taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      capSrc_q <= SRC_NONE;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= read ? rdWord : 32'h0000_0000;
        capSrc_q <= cur_q;
      end
    end
  end

  // outputs straight from flops
  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign txByte = txByte_q;
  assign txDmaRequest_n = txReqN_q;
  assign rxDmaRequest_n = rxReqN_q;
  assign irq = irq_q;
endmodule

/* File: tb/uart_fifo_ctrl_monitor.sv */
// assertions on the port behaviour of the fifo control block
`timescale 1ns/1ps
// ----------
// checker
// ----------
module uart_fifo_ctrl_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // serial side events
  input wire uart_fifo_ctrl_pkg::rxchar_s rxChar,
  input wire logic charTick,
  input wire logic txLoad,
  // dma pins
  input wire logic txDmaRequest_n,
  input wire logic rxDmaRequest_n
);
  import uart_fifo_ctrl_pkg::*;
  // accepted transfers by kind, and what may move each pin
  wire ack = (read || write) && !waitrequest;
  wire statRd = read && ack && address[3:2] == 2'h2;
  wire ctlWr = write && ack && address[3:2] == 2'h2;
  wire rxFill = rxChar.valid || charTick || ctlWr;
  wire rxDrain = (read && ack && address[3:2] == 2'h0) || ctlWr;
  wire txFill = (write && ack && address[3:2] == 2'h0) || ctlWr;
  wire txDrain = txLoad || ctlWr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a request is answered with one cycle of waitrequest low
  sequence reqSeen;
    (read || write) && waitrequest;
  endsequence
  sequence oneAnswer;
    !waitrequest ##1 waitrequest;
  endsequence
  a_wait_one_cycle: assert property (reqSeen |=> oneAnswer)
    else $error("waitrequest not low for one cycle");
  a_status_fixed_bits:
    assert property (statRd |-> !readdata[4] && readdata[7] == readdata[6])
    else $error("status bits 7..4 inconsistent");
  a_none_code:
    assert property (statRd && readdata[0] |-> readdata[3:0] == 4'h1)
    else $error("no-pending code wrong");
  a_code_legal:
    assert property (statRd |-> readdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hC})
    else $error("illegal interrupt code");
  a_deep_needs_en:
    assert property (statRd && !readdata[6] |-> !readdata[5])
    else $error("64-byte flag without fifos");
  a_rxpin_rise:
    assert property ($rose(rxDmaRequest_n) |-> $past(rxDrain) || $past(rxDrain, 2))
    else $error("rx request released without a drain");
  a_rxpin_fall:
    assert property ($fell(rxDmaRequest_n) |-> $past(rxFill) || $past(rxFill, 2))
    else $error("rx request raised without a fill");
  a_txpin_rise:
    assert property ($rose(txDmaRequest_n) |-> $past(txFill) || $past(txFill, 2))
    else $error("tx request released without a write");
  a_txpin_fall:
    assert property ($fell(txDmaRequest_n) |-> $past(txDrain) || $past(txDrain, 2))
    else $error("tx request raised without a drain");
endmodule

/* File: tb/serial_side_model.sv */
// serial side model: receive characters, ticks, line and modem events, tx loads
`timescale 1ns/1ps
// ----------
// model
// ----------
module serial_side_model (
  // clock
  input wire logic clk,
  // events toward the block
  output uart_fifo_ctrl_pkg::rxchar_s rxChar,
  output logic charTick,
  output logic txLoad,
  output logic lineError,
  output logic modemChange
);
  import uart_fifo_ctrl_pkg::*;
  logic [4:0] evQ = 5'h00;
  logic [7:0] datQ = 8'h00;
  // one-cycle pulses; data shows its inverse while not valid
  assign rxChar = {evQ[0], datQ};
  assign charTick = evQ[1];
  assign txLoad = evQ[2];
  assign lineError = evQ[3];
  assign modemChange = evQ[4];
  // one event burst, then two idle cycles
  task pulse(input logic [4:0] m, input logic [7:0] d);
    @(posedge clk);
    evQ <= m;
    datQ <= d;
    @(posedge clk);
    evQ <= 5'h00;
    datQ <= ~d;
    repeat (2) @(posedge clk);
  endtask
endmodule

/* File: tb/uart_fifo_ctrl_int_status_test.sv */
// self-checking bench of the fifo control block
`timescale 1ns/1ps
// ----------
// bench
// ----------
module uart_fifo_ctrl_int_status_test;
  import uart_fifo_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  rxchar_s rxChar;
  txbyte_s txByte;
  logic lineError, charTick, txLoad, modemChange, txDmaRequest_n, rxDmaRequest_n, irq;
  logic [31:0] seed = 32'hf77c_7d4d;
  logic [31:0] expQ[$];
  logic [7:0] rxD[$];
  logic [7:0] txD[$];
  logic [7:0] b;
  int trig[8] = '{1, 4, 8, 14, 1, 16, 32, 56};
  int badCount = 0;
  int nCompared = 0;
  int cyc = 0;
  uart_fifo_ctrl dut (
    .clk(clk),
    .rst_b(rst_b),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .rxChar(rxChar),
    .lineError(lineError),
    .charTick(charTick),
    .txLoad(txLoad),
    .txByte(txByte),
    .modemChange(modemChange),
    .txDmaRequest_n(txDmaRequest_n),
    .rxDmaRequest_n(rxDmaRequest_n),
    .irq(irq)
  );
  serial_side_model ser (
    .clk(clk),
    .rxChar(rxChar),
    .charTick(charTick),
    .txLoad(txLoad),
    .lineError(lineError),
    .modemChange(modemChange)
  );
  // clock
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task endSim();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = rnd();
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {r[31:8], d};
    byteenable <= {r[2:0], 1'b1};
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task putc();
    b = 8'(rnd());
    rxD.push_back(b);
    ser.pulse(5'h01, b);
  endtask
  task settle();
    repeat (3) @(posedge clk);
  endtask
  task pin(input logic s, input logic e);
    check({31'h0, s}, {31'h0, e});
  endtask
  // answers and sent bytes compared against the oldest note; hang limit
  always @(posedge clk) begin
    cyc++;
    if (read && waitrequest === 1'b0 && expQ.size() > 0) begin
      check(readdata, expQ.pop_front());
    end
    if (txByte.valid === 1'b1 && txD.size() > 0) begin
      check(32'(txByte.data), 32'(txD.pop_front()));
    end
    if (cyc == 20000) begin
      badCount++;
      endSim();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(4'h8, 32'h0000_0001);
    bus(1'b1, 4'h8, 8'hE8);
    rd(4'h8, 32'h0000_0001);
    // clear bits written without enable must leave the holding byte alone
    putc();
    bus(1'b1, 4'h8, 8'h06);
    rd(4'hC, 32'h0000_0001);
    bus(1'b1, 4'h8, 8'h21);
    rd(4'h8, 32'h0000_00E1);
    bus(1'b1, 4'h4, 8'h01);
    for (int m = 0; m < 2; m++) begin
      for (int t = 0; t < 4; t++) begin
        bus(1'b1, 4'h8, {t[1:0], m[0], 5'h03});
        rxD.delete();
        rd(4'hC, 32'h0000_0000);
        repeat (trig[m * 4 + t] - 1) putc();
        rd(4'h8, {24'h00_0000, 2'b11, m[0], 5'h01});
        putc();
        rd(4'h8, {24'h00_0000, 2'b11, m[0], 5'h04});
        rd(4'hC, 32'(trig[m * 4 + t]));
      end
    end
    repeat (8) putc();
    rd(4'hC, 32'h0000_0040);
    bus(1'b1, 4'h8, 8'h43);
    rxD.delete();
    putc();
    repeat (3) ser.pulse(5'h02, 8'h00);
    rd(4'h8, 32'h0000_00C1);
    ser.pulse(5'h02, 8'h00);
    rd(4'h8, 32'h0000_00CC);
    rd(4'h0, 32'(rxD.pop_front()));
    rd(4'h8, 32'h0000_00C1);
    bus(1'b1, 4'h4, 8'h0F);
    bus(1'b1, 4'h8, 8'h0F);
    rd(4'h8, 32'h0000_00C2);
    rd(4'h8, 32'h0000_00C1);
    repeat (16) begin
      b = 8'(rnd());
      txD.push_back(b);
      bus(1'b1, 4'h0, b);
    end
    settle();
    pin(txDmaRequest_n, 1'b1);
    rd(4'hC, 32'h0010_0000);
    repeat (7) ser.pulse(5'h04, 8'h00);
    pin(txDmaRequest_n, 1'b1);
    ser.pulse(5'h04, 8'h00);
    pin(txDmaRequest_n, 1'b0);
    bus(1'b1, 4'h8, 8'h0D);
    txD.delete();
    rd(4'hC, 32'h0000_0000);
    rd(4'h8, 32'h0000_00C2);
    bus(1'b1, 4'h0, 8'h5A);
    rd(4'hC, 32'h0001_0000);
    bus(1'b1, 4'h8, 8'h4B);
    rxD.delete();
    repeat (3) putc();
    pin(rxDmaRequest_n, 1'b1);
    putc();
    pin(rxDmaRequest_n, 1'b0);
    repeat (3) rd(4'h0, 32'(rxD.pop_front()));
    settle();
    pin(rxDmaRequest_n, 1'b0);
    rd(4'h0, 32'(rxD.pop_front()));
    settle();
    pin(rxDmaRequest_n, 1'b1);
    bus(1'b1, 4'h8, 8'h03);
    rxD.delete();
    putc();
    rd(4'h8, 32'h0000_00C4);
    pin(irq, 1'b1);
    ser.pulse(5'h18, 8'h00);
    rd(4'h8, 32'h0000_00C4);
    rd(4'h0, 32'(rxD.pop_front()));
    rd(4'h8, 32'h0000_00C6);
    rd(4'h8, 32'h0000_00C0);
    rd(4'h8, 32'h0000_00C1);
    settle();
    pin(irq, 1'b0);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    pin(txDmaRequest_n, 1'b0);
    pin(rxDmaRequest_n, 1'b1);
    rd(4'h8, 32'h0000_0001);
    settle();
    check(32'(expQ.size()), 32'h0000_0000);
    endSim();
  end
endmodule
bind uart_fifo_ctrl uart_fifo_ctrl_monitor mon (
  .clk(clk),
  .rst_b(rst_b),
  .address(address),
  .read(read),
  .write(write),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .rxChar(rxChar),
  .charTick(charTick),
  .txLoad(txLoad),
  .txDmaRequest_n(txDmaRequest_n),
  .rxDmaRequest_n(rxDmaRequest_n)
);
